// ### smw_consts.svh
// register offsets, field positions and reset values of the window measure timer
`ifndef SMW_CONSTS_SVH
`define SMW_CONSTS_SVH

// ****************************************************************
// register word indices (byte address is four times the index)
// ****************************************************************
`define SMW_IDX_IRQ_EN      6'h00
`define SMW_IDX_IRQ_FLAG    6'h01
`define SMW_IDX_CLK_SEL     6'h02
`define SMW_IDX_CTRL0       6'h03
`define SMW_IDX_CTRL1       6'h04
`define SMW_IDX_CPR_LOW     6'h05
`define SMW_IDX_CPR_HIGH    6'h06
`define SMW_IDX_CPR_UPPER   6'h07
`define SMW_IDX_CPW_LOW     6'h08
`define SMW_IDX_CPW_HIGH    6'h09
`define SMW_IDX_CPW_UPPER   6'h0A
`define SMW_IDX_PR_LOW      6'h0B
`define SMW_IDX_PR_HIGH     6'h0C
`define SMW_IDX_PR_UPPER    6'h0D
`define SMW_IDX_SIG_SEL     6'h0E
`define SMW_IDX_STATUS      6'h0F
`define SMW_IDX_CNT_LOW     6'h10
`define SMW_IDX_CNT_HIGH    6'h11
`define SMW_IDX_CNT_UPPER   6'h12
`define SMW_IDX_WIN_SEL     6'h13

// ****************************************************************
// field positions
// ****************************************************************
`define SMW_IRQ_PW_BIT      2
`define SMW_IRQ_PR_BIT      1
`define SMW_IRQ_MATCH_BIT   0
`define SMW_CTRL0_EN_BIT    7
`define SMW_CTRL0_STP_BIT   5
`define SMW_CTRL0_WPOL_BIT  4
`define SMW_CTRL0_SPOL_BIT  3
`define SMW_CTRL0_CPOL_BIT  2
`define SMW_CTRL1_GO_BIT    7
`define SMW_CTRL1_RPT_BIT   6
`define SMW_CTRL1_ASYN_BIT  5
`define SMW_STAT_RST_BIT    5

// ****************************************************************
// encodings and reset values
// ****************************************************************
`define SMW_MODE_WINDOWED   4'h5
`define SMW_RST_BYTE        8'h00
`define SMW_RST_PERIOD      24'hFFFFFF
`define SMW_RST_COUNT       24'h000000

`endif

// ### smw_pkg.sv
// types shared by the window measure timer files
package smw_pkg;

  // ****************************************************************
  // classic wishbone request from the master
  // ****************************************************************
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } smw_wb_req_s;

  // ****************************************************************
  // measurement sequencer, gray along idle, armed, measuring
  // ****************************************************************
  typedef enum logic [1:0] {
    SMW_IDLE  = 2'h0,
    SMW_ARMED = 2'h1,
    SMW_MEAS  = 2'h3
  } smw_state_e;

endpackage

// ### smw_sync2.sv
// two flip-flop synchroniser of parameterised width
`timescale 1ns/1ps

module smw_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ### smw_timer.sv
// window measure timer with capture registers, interrupts and wishbone slave
//
// Behaviour
// - rising window edge starts the timer counting
// - next rising edge captures period, clears timer
// - three interrupt sources: width, period, match
// - width capture sets width flag, enable gates irq
// - period capture sets period flag, enable gates irq
// - sync modes align trigger, async modes do not
// - every trigger synchronised before flag is set
// - timer equal period limit sets match flag unless a period capture falls on the same tick
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "smw_consts.svh"

module smw_timer (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  // wishbone slave
  input  wire smw_pkg::smw_wb_req_s wb_req,
  output logic                      wb_ack,
  output logic [31:0]               wb_dat_r,
  // window input pins
  input  wire logic [7:0]           window_input,
  // interrupt
  output logic                      irq
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [2:0]          irq_enable;
  logic [2:0]          irq_flag;
  logic [2:0]          clk_sel;
  logic                en;
  logic                stp;
  logic                wpol;
  logic                spol;
  logic                cpol;
  logic [1:0]          prescale;
  logic                go;
  logic                repeat_en;
  logic                async_trig;
  logic [3:0]          mode;
  logic [4:0]          sig_sel;
  logic [4:0]          win_sel;
  logic [23:0]         period_capture_reg;
  logic [23:0]         width_capture_reg;
  logic [23:0]         period_limit_reg;
  logic [23:0]         count_reg;
  logic [2:0]          pre_cnt;
  logic                win_prev;
  logic [2:0]          trig_aligned;
  smw_pkg::smw_state_e state;
  smw_pkg::smw_state_e next_state;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire       acc    = wb_req.cyc && wb_req.stb && !wb_ack;
  wire       wr     = acc && wb_req.we && wb_req.sel[0];
  wire [5:0] idx    = wb_req.adr[7:2];
  wire [7:0] wdat   = wb_req.dat[7:0];

  // per register write strobes
  wire wr_ie     = wr && (idx == `SMW_IDX_IRQ_EN);
  wire wr_flag   = wr && (idx == `SMW_IDX_IRQ_FLAG);
  wire wr_clk    = wr && (idx == `SMW_IDX_CLK_SEL);
  wire wr_ctrl0  = wr && (idx == `SMW_IDX_CTRL0);
  wire wr_ctrl1  = wr && (idx == `SMW_IDX_CTRL1);
  wire wr_pr_l   = wr && (idx == `SMW_IDX_PR_LOW);
  wire wr_pr_h   = wr && (idx == `SMW_IDX_PR_HIGH);
  wire wr_pr_u   = wr && (idx == `SMW_IDX_PR_UPPER);
  wire wr_sig    = wr && (idx == `SMW_IDX_SIG_SEL);
  wire wr_stat   = wr && (idx == `SMW_IDX_STATUS);
  wire wr_cnt_l  = wr && (idx == `SMW_IDX_CNT_LOW);
  wire wr_cnt_h  = wr && (idx == `SMW_IDX_CNT_HIGH);
  wire wr_cnt_u  = wr && (idx == `SMW_IDX_CNT_UPPER);
  wire wr_win    = wr && (idx == `SMW_IDX_WIN_SEL);
  wire wr_cnt    = wr_cnt_l || wr_cnt_h || wr_cnt_u;
  wire rst_req   = wr_stat && wdat[`SMW_STAT_RST_BIT];

  // ****************************************************************
  // window input path
  // ****************************************************************
  logic [7:0] win_sync;

  // pins cross into the clock domain first
  smw_sync2 #(
    .WIDTH (8)
  ) u_win_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       (window_input),
    .q       (win_sync)
  );

  // selected window level with polarity and edges
  wire win_lvl  = win_sync[win_sel[2:0]] ^ wpol;
  wire win_rise = win_lvl && !win_prev;
  wire win_fall = !win_lvl && win_prev;

  // previous level for edge detection
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      win_prev <= 1'b0;
    end else begin
      win_prev <= win_lvl;
    end
  end

  // ****************************************************************
  // prescaler giving the count tick
  // ****************************************************************
  wire tick = (prescale == 2'h0) ? 1'b1 :
              (prescale == 2'h1) ? (pre_cnt[0] == 1'b0) :
              (prescale == 2'h2) ? (pre_cnt[1:0] == 2'h0) :
                                   (pre_cnt == 3'h0);

  // prescale counter, runs while measuring, cleared to zero in idle and armed
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pre_cnt <= 3'h0;
    end else if (state == smw_pkg::SMW_MEAS) begin
      pre_cnt <= pre_cnt + 3'h1;
    end else begin
      pre_cnt <= 3'h0;
    end
  end

  // ****************************************************************
  // measurement sequencer
  // ****************************************************************
  wire run       = en && go && (mode == `SMW_MODE_WINDOWED);
  wire measuring = (state == smw_pkg::SMW_MEAS);
  wire cap_pr    = run && measuring && win_rise;
  wire cap_pw    = run && measuring && win_fall;
  wire match_hit = run && measuring && tick && !cap_pr && (count_reg == period_limit_reg);

  // next state selection
  always_comb begin
    next_state = state;
    case (state)
      smw_pkg::SMW_IDLE: begin
        if (run) begin
          next_state = smw_pkg::SMW_ARMED;
        end
      end
      smw_pkg::SMW_ARMED: begin
        if (!run) begin
          next_state = smw_pkg::SMW_IDLE;
        end else if (win_rise) begin
          next_state = smw_pkg::SMW_MEAS;
        end
      end
      smw_pkg::SMW_MEAS: begin
        if (!run) begin
          next_state = smw_pkg::SMW_IDLE;
        end else if (win_rise && !repeat_en) begin
          next_state = smw_pkg::SMW_IDLE;
        end
      end
      default: begin
        next_state = smw_pkg::SMW_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= smw_pkg::SMW_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // timer and captures
  // ****************************************************************
  wire        arm_start = run && (state == smw_pkg::SMW_ARMED) && win_rise;
  wire [23:0] cnt_load  = {wr_cnt_u ? wdat : count_reg[23:16],
                           wr_cnt_h ? wdat : count_reg[15:8],
                           wr_cnt_l ? wdat : count_reg[7:0]};
  wire [23:0] next_count =
    wr_cnt                          ? cnt_load :
    (rst_req || arm_start)          ? `SMW_RST_COUNT :
    (cap_pr || match_hit)           ? `SMW_RST_COUNT :
    (measuring && run && tick)      ? count_reg + 24'h000001 :
                                      count_reg;

  // timer register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_reg <= `SMW_RST_COUNT;
    end else begin
      count_reg <= next_count;
    end
  end

  // capture registers take the timer before it clears
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      period_capture_reg <= `SMW_RST_COUNT;
      width_capture_reg  <= `SMW_RST_COUNT;
    end else begin
      if (cap_pr) begin
        period_capture_reg <= count_reg;
      end
      if (cap_pw) begin
        width_capture_reg <= count_reg;
      end
    end
  end

  // ****************************************************************
  // interrupt triggers and flags
  // ****************************************************************
  wire [2:0] trig_raw = {cap_pw, cap_pr, match_hit};
  wire [2:0] trig_pick = async_trig ? trig_raw : trig_aligned;
  logic [2:0] trig_cpu;

  // alignment stage used in synchronous modes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      trig_aligned <= 3'h0;
    end else begin
      trig_aligned <= trig_raw;
    end
  end

  // every trigger crosses a synchroniser before the flag
  smw_sync2 #(
    .WIDTH (3)
  ) u_trig_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       (trig_pick),
    .q       (trig_cpu)
  );

  // sticky flags, write one clears, a new event wins
  wire [2:0] flag_clr  = wr_flag ? wdat[2:0] : 3'h0;
  wire [2:0] next_flag = (irq_flag & ~flag_clr) | trig_cpu;

  // flag register and masked interrupt output
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_flag <= 3'h0;
      irq      <= 1'b0;
    end else begin
      irq_flag <= next_flag;
      irq      <= |(irq_flag & irq_enable);
    end
  end

  // ****************************************************************
  // software control registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_enable <= 3'h0;
      clk_sel    <= 3'h0;
      sig_sel    <= 5'h00;
      win_sel    <= 5'h00;
    end else begin
      if (wr_ie) irq_enable <= wdat[2:0];
      if (wr_clk) clk_sel <= wdat[2:0];
      if (wr_sig) sig_sel <= wdat[4:0];
      if (wr_win) win_sel <= wdat[4:0];
    end
  end

  // mode and polarity control
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {en, stp, wpol, spol, cpol, prescale} <= 7'h00;
      {repeat_en, async_trig, mode}         <= 6'h00;
    end else begin
      if (wr_ctrl0) begin
        en       <= wdat[`SMW_CTRL0_EN_BIT];
        stp      <= wdat[`SMW_CTRL0_STP_BIT];
        wpol     <= wdat[`SMW_CTRL0_WPOL_BIT];
        spol     <= wdat[`SMW_CTRL0_SPOL_BIT];
        cpol     <= wdat[`SMW_CTRL0_CPOL_BIT];
        prescale <= wdat[1:0];
      end
      if (wr_ctrl1) begin
        repeat_en  <= wdat[`SMW_CTRL1_RPT_BIT];
        async_trig <= wdat[`SMW_CTRL1_ASYN_BIT];
        mode       <= wdat[3:0];
      end
    end
  end

  // go bit: software sets, a single shot capture clears it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      go <= 1'b0;
    end else if (wr_ctrl1) begin
      go <= wdat[`SMW_CTRL1_GO_BIT];
    end else if (cap_pr && !repeat_en) begin
      go <= 1'b0;
    end
  end

  // period limit bytes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      period_limit_reg <= `SMW_RST_PERIOD;
    end else begin
      if (wr_pr_l) period_limit_reg[7:0]   <= wdat;
      if (wr_pr_h) period_limit_reg[15:8]  <= wdat;
      if (wr_pr_u) period_limit_reg[23:16] <= wdat;
    end
  end

  // ****************************************************************
  // read data selection
  // ****************************************************************
  wire [7:0] stat_rd = {2'h0, 1'b0, 2'h0, measuring, win_lvl, (state != smw_pkg::SMW_IDLE)};
  logic [7:0] rd_byte;

  always_comb begin
    case (idx)
      `SMW_IDX_IRQ_EN:    rd_byte = {5'h00, irq_enable};
      `SMW_IDX_IRQ_FLAG:  rd_byte = {5'h00, irq_flag};
      `SMW_IDX_CLK_SEL:   rd_byte = {5'h00, clk_sel};
      `SMW_IDX_CTRL0:     rd_byte = {en, 1'b0, stp, wpol, spol, cpol, prescale};
      `SMW_IDX_CTRL1:     rd_byte = {go, repeat_en, async_trig, 1'b0, mode};
      `SMW_IDX_CPR_LOW:   rd_byte = period_capture_reg[7:0];
      `SMW_IDX_CPR_HIGH:  rd_byte = period_capture_reg[15:8];
      `SMW_IDX_CPR_UPPER: rd_byte = period_capture_reg[23:16];
      `SMW_IDX_CPW_LOW:   rd_byte = width_capture_reg[7:0];
      `SMW_IDX_CPW_HIGH:  rd_byte = width_capture_reg[15:8];
      `SMW_IDX_CPW_UPPER: rd_byte = width_capture_reg[23:16];
      `SMW_IDX_PR_LOW:    rd_byte = period_limit_reg[7:0];
      `SMW_IDX_PR_HIGH:   rd_byte = period_limit_reg[15:8];
      `SMW_IDX_PR_UPPER:  rd_byte = period_limit_reg[23:16];
      `SMW_IDX_SIG_SEL:   rd_byte = {3'h0, sig_sel};
      `SMW_IDX_STATUS:    rd_byte = stat_rd;
      `SMW_IDX_CNT_LOW:   rd_byte = count_reg[7:0];
      `SMW_IDX_CNT_HIGH:  rd_byte = count_reg[15:8];
      `SMW_IDX_CNT_UPPER: rd_byte = count_reg[23:16];
      `SMW_IDX_WIN_SEL:   rd_byte = {3'h0, win_sel};
      default:            rd_byte = `SMW_RST_BYTE;
    endcase
  end

  // ****************************************************************
  // bus answer, one wait cycle then ack for one cycle
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wb_ack   <= 1'b0;
      wb_dat_r <= 32'h00000000;
    end else begin
      wb_ack   <= acc;
      wb_dat_r <= acc ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

endmodule

// ### smw_timer_props.sv
// concurrent checks on the window measure timer ports
`timescale 1ns/1ps
`include "smw_consts.svh"

module smw_timer_props (
  // clock and reset
  input wire logic                 clk_sys,
  input wire logic                 nrst,
  // bus, pins and interrupt
  input wire smw_pkg::smw_wb_req_s wb_req,
  input wire logic                 wb_ack,
  input wire logic [31:0]          wb_dat_r,
  input wire logic [7:0]           window_input,
  input wire logic                 irq
);
  // ******************
  // bus decode
  // ******************
  wire logic       take = wb_req.cyc & wb_req.stb & ~wb_ack;
  wire logic       wr   = take & wb_req.we & wb_req.sel[0];
  wire logic [5:0] idx  = wb_req.adr[7:2];
  logic [2:0]      en_m;
  logic [23:0]     lim_m;
  wire logic [7:0] lim_b = (idx == `SMW_IDX_PR_LOW) ? lim_m[7:0] :
                           (idx == `SMW_IDX_PR_HIGH) ? lim_m[15:8] : lim_m[23:16];

  // mirrors of enable and period limit
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      en_m  <= 3'h0;
      lim_m <= `SMW_RST_PERIOD;
    end else if (wr) begin
      if (idx == `SMW_IDX_IRQ_EN) en_m <= wb_req.dat[2:0];
      if (idx == `SMW_IDX_PR_LOW) lim_m[7:0] <= wb_req.dat[7:0];
      if (idx == `SMW_IDX_PR_HIGH) lim_m[15:8] <= wb_req.dat[7:0];
      if (idx == `SMW_IDX_PR_UPPER) lim_m[23:16] <= wb_req.dat[7:0];
    end
  end

  // ******************
  // properties
  // ******************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_rd(ix);
    (take && !wb_req.we && idx == ix) ##1 wb_ack;
  endsequence
  sequence s_rd_lim;
    (take && !wb_req.we && idx >= `SMW_IDX_PR_LOW && idx <= `SMW_IDX_PR_UPPER) ##1 wb_ack;
  endsequence
  sequence s_mask_off;
    (wr && idx == `SMW_IDX_IRQ_EN && wb_req.dat[2:0] == 3'h0) ##1 wb_ack;
  endsequence

  property p_ack_follows; take |=> wb_ack; endproperty
  property p_ack_pulse; wb_ack |=> !wb_ack; endproperty
  property p_dat_idle; !wb_ack |-> wb_dat_r == 32'h0; endproperty
  property p_lane; wb_ack |-> wb_dat_r[31:8] == 24'h0; endproperty
  property p_src; s_rd(`SMW_IDX_IRQ_FLAG) |-> wb_dat_r[7:3] == 5'h0; endproperty
  property p_en_rd; s_rd(`SMW_IDX_IRQ_EN) |-> wb_dat_r[2:0] == en_m; endproperty
  property p_lim_rd; s_rd_lim |-> wb_dat_r[7:0] == lim_b; endproperty
  property p_irq_gate; irq |-> $past(en_m) != 3'h0; endproperty
  property p_mask_off; s_mask_off |=> !irq; endproperty

  a_ack_follows: assert property (p_ack_follows) else $error("ack missing");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  a_lane: assert property (p_lane) else $error("upper read lanes set");
  a_src: assert property (p_src) else $error("extra flag bits");
  a_en_rd: assert property (p_en_rd) else $error("enable readback wrong");
  a_lim_rd: assert property (p_lim_rd) else $error("limit readback wrong");
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
  a_mask_off: assert property (p_mask_off) else $error("irq kept after mask");

  c_window: cover property ($rose(window_input[0]));
endmodule

bind smw_timer smw_timer_props i_props (
  .clk_sys(clk_sys), .nrst(nrst), .wb_req(wb_req), .wb_ack(wb_ack),
  .wb_dat_r(wb_dat_r), .window_input(window_input), .irq(irq));

// ### smw_timer_tb.sv
// self-checking bench of the window measure timer
`timescale 1ns/1ps
`include "smw_consts.svh"

module smw_timer_tb;
  // ******************
  // signals
  // ******************
  logic                 clk_sys;
  logic                 nrst;
  smw_pkg::smw_wb_req_s wb_req;
  logic                 wb_ack;
  logic [31:0]          wb_dat_r;
  logic [7:0]           window_input;
  logic                 irq;
  int                   error_cnt;
  int                   n_tests;
  logic [7:0]           rd;
  logic [7:0]           p1;
  logic [7:0]           w1;
  int                   d_s;
  int                   d_a;
  typedef struct {logic wr; logic [5:0] ix; logic [7:0] d; logic [7:0] e;} smw_row_s;
  smw_row_s             rows[13];

  smw_timer i_dut (.clk_sys(clk_sys), .nrst(nrst), .wb_req(wb_req), .wb_ack(wb_ack),
    .wb_dat_r(wb_dat_r), .window_input(window_input), .irq(irq));

  // clock at 25 MHz
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ******************
  // tasks
  // ******************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic wr, input logic [5:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: wr, sel: 4'hF, adr: {ix, 2'b00}, dat: {24'h0, d}};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1);
    rd = wb_dat_r[7:0];
    wb_req <= '0;
    chk8(8'(n), 8'h02);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic pin(input logic v);
    @(posedge clk_sys);
    window_input[0] <= v;
  endtask

  // cycles from a window rise to the interrupt
  task automatic time_rise(output int d);
    d = 0;
    pin(1'b1);
    do begin
      @(posedge clk_sys);
      d++;
    end while (irq !== 1'b1 && d < 30);
  endtask

  task automatic fin(input string s);
    $display("test %s done, mismatches so far %0d", s, error_cnt);
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ******************
  // main sequence
  // ******************
  initial begin
    error_cnt = 0;
    n_tests = 0;
    nrst = 1'b0;
    wb_req = '0;
    window_input = 8'h00;
    rows = '{
      '{1'b0, `SMW_IDX_IRQ_EN, 8'h00, 8'h00},
      '{1'b0, `SMW_IDX_IRQ_FLAG, 8'h00, 8'h00},
      '{1'b0, `SMW_IDX_PR_LOW, 8'h00, 8'hFF},
      '{1'b0, `SMW_IDX_PR_UPPER, 8'h00, 8'hFF},
      '{1'b1, `SMW_IDX_PR_LOW, 8'h40, 8'h00},
      '{1'b1, `SMW_IDX_PR_HIGH, 8'h00, 8'h00},
      '{1'b1, `SMW_IDX_PR_UPPER, 8'h00, 8'h00},
      '{1'b0, `SMW_IDX_PR_LOW, 8'h00, 8'h40},
      '{1'b1, `SMW_IDX_CPR_LOW, 8'h55, 8'h00},
      '{1'b0, `SMW_IDX_CPR_LOW, 8'h00, 8'h00},
      '{1'b1, 6'h3F, 8'hAA, 8'h00},
      '{1'b0, 6'h3F, 8'h00, 8'h00},
      '{1'b0, `SMW_IDX_CNT_LOW, 8'h00, 8'h00}};
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      wb(rows[i].wr, rows[i].ix, rows[i].d);
      if (!rows[i].wr) chk8(rd, rows[i].e);
    end
    fin("registers");
    // window period and width capture
    wb(1'b1, `SMW_IDX_IRQ_EN, 8'h02);
    wb(1'b1, `SMW_IDX_CTRL0, 8'h80);
    wb(1'b1, `SMW_IDX_CTRL1, 8'hC5);
    tick(10);
    wb(1'b0, `SMW_IDX_CNT_LOW, 8'h00);
    chk8(rd, 8'h00);
    pin(1'b1);
    tick(7);
    pin(1'b0);
    tick(11);
    pin(1'b1);
    tick(12);
    wb(1'b0, `SMW_IDX_CPR_LOW, 8'h00);
    p1 = rd;
    wb(1'b0, `SMW_IDX_CPW_LOW, 8'h00);
    w1 = rd;
    chk8(p1 - w1, 8'h0C);
    chk1(p1 inside {8'h13, 8'h14}, 1'b1);
    wb(1'b0, `SMW_IDX_CPR_HIGH, 8'h00);
    chk8(rd, 8'h00);
    wb(1'b0, `SMW_IDX_IRQ_FLAG, 8'h00);
    chk8(rd, 8'h06);
    chk1(irq, 1'b1);
    wb(1'b1, `SMW_IDX_IRQ_EN, 8'h00);
    tick(2);
    chk1(irq, 1'b0);
    wb(1'b1, `SMW_IDX_IRQ_EN, 8'h04);
    tick(2);
    chk1(irq, 1'b1);
    wb(1'b1, `SMW_IDX_IRQ_FLAG, 8'h06);
    wb(1'b0, `SMW_IDX_IRQ_FLAG, 8'h00);
    chk8(rd, 8'h00);
    tick(2);
    chk1(irq, 1'b0);
    fin("window");
    // aligned against unaligned trigger path
    wb(1'b1, `SMW_IDX_IRQ_EN, 8'h02);
    pin(1'b0);
    tick(8);
    wb(1'b1, `SMW_IDX_IRQ_FLAG, 8'h07);
    time_rise(d_s);
    wb(1'b1, `SMW_IDX_CTRL1, 8'hE5);
    pin(1'b0);
    tick(8);
    wb(1'b1, `SMW_IDX_IRQ_FLAG, 8'h07);
    time_rise(d_a);
    chk8(8'(d_s - d_a), 8'h01);
    chk1(d_a >= 4, 1'b1);
    fin("trigger");
    // period match against a small limit
    wb(1'b1, `SMW_IDX_PR_LOW, 8'h0A);
    wb(1'b1, `SMW_IDX_IRQ_EN, 8'h01);
    wb(1'b1, `SMW_IDX_STATUS, 8'h20);
    wb(1'b1, `SMW_IDX_IRQ_FLAG, 8'h07);
    tick(30);
    wb(1'b0, `SMW_IDX_IRQ_FLAG, 8'h00);
    chk8(rd, 8'h01);
    chk1(irq, 1'b1);
    wb(1'b0, `SMW_IDX_CNT_LOW, 8'h00);
    chk1(rd <= 8'h0A, 1'b1);
    fin("match");
    // reset in mid-run
    @(posedge clk_sys);
    nrst <= 1'b0;
    tick(2);
    chk1(irq, 1'b0);
    nrst <= 1'b1;
    wb(1'b0, `SMW_IDX_PR_LOW, 8'h00);
    chk8(rd, 8'hFF);
    wb(1'b0, `SMW_IDX_IRQ_FLAG, 8'h00);
    chk8(rd, 8'h00);
    fin("reset");
    // single shot on the second window pin
    wb(1'b1, `SMW_IDX_WIN_SEL, 8'h01);
    wb(1'b1, `SMW_IDX_CTRL0, 8'h80);
    wb(1'b1, `SMW_IDX_CTRL1, 8'h85);
    repeat (2) begin
      window_input[1] <= 1'b1;
      tick(6);
      window_input[1] <= 1'b0;
      tick(6);
    end
    wb(1'b0, `SMW_IDX_CTRL1, 8'h00);
    chk8(rd, 8'h05);
    wb(1'b0, `SMW_IDX_CPR_LOW, 8'h00);
    chk1(rd inside {8'h0B, 8'h0C}, 1'b1);
    wb(1'b0, `SMW_IDX_IRQ_FLAG, 8'h00);
    chk8(rd, 8'h06);
    fin("single");
    test_done;
  end

  // watchdog well beyond the expected run
  initial begin
    repeat (3000) @(posedge clk_sys);
    chk1(1'b0, 1'b1);
    test_done;
  end
endmodule
